// File: src/pmcc_params.svh
// pmcc_params.svh: register offsets, field positions, reset values and
// timing counts for the clock controller.
// assumes: included by bare name from the package only; the modules see its macros without an include.
// Summary of operation
// - count main clocks over sixteen slow periods
// - valid flag only when oscillator on, count ready
// - divider zero stops, one bypasses, else divides
// - pll write restarts settle count, then lock
// - multiplier zero disables pll, else times plus one; modelled as one tick per divided tick
// - usb divider one, two, four; eleven reserved
// - source slow, main, pll; ten reserved
// - master prescaler powers of two, seven reserved
// - three outputs with own source and prescaler
// - enable register ones set enable bits
// - disable register ones clear enable bits
// - oscillator stable flag follows oscillator
// - lock flag shows pll locked
// - master ready flag shows master clock ready
// - each output ready flag shows its readiness
// - mask view reads zero enabled, one disabled
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH
`define PMCC_OFS_OSC_CTRL 12'h020
`define PMCC_OFS_MEASURE 12'h024
`define PMCC_OFS_PLL 12'h02C
`define PMCC_OFS_MCK 12'h030
`define PMCC_OFS_PCK0 12'h040
`define PMCC_OFS_PCK1 12'h044
`define PMCC_OFS_PCK2 12'h048
`define PMCC_OFS_IER 12'h060
`define PMCC_OFS_IDR 12'h064
`define PMCC_OFS_SR 12'h068
`define PMCC_OFS_IMR 12'h06C
`define PMCC_OFS_IRQ_CLR 12'h070
`define PMCC_OFS_IRQ_STAT 12'h074
// status bit positions
`define PMCC_BIT_OSC 0
`define PMCC_BIT_LOCK 2
`define PMCC_BIT_MRDY 3
`define PMCC_BIT_PRDY0 8
`define PMCC_STAT_MASK 32'h0000070D
// pll register fields
`define PMCC_PLL_DIV_LSB 0
`define PMCC_PLL_CNT_LSB 8
`define PMCC_PLL_RANGE_LSB 14
`define PMCC_PLL_MUL_LSB 16
`define PMCC_PLL_USB_LSB 28
`define PMCC_PLL_MASK 32'h37FFFFFF
`define PMCC_CLK_MASK 32'h0000001F
`define PMCC_MEAS_VALID_BIT 16
`define PMCC_MEAS_WINDOW 5'h10
`define PMCC_MCK_RESET 32'h00000001
`define PMCC_PLL_RESET 32'h00003F00
`endif

// File: src/pmcc_pkg.sv
// pmcc_pkg.sv: types shared by the clock controller modules.
// assumes: pmcc_params.svh is on the include path.
package pmcc_pkg;
  `include "pmcc_params.svh"
  typedef enum logic [1:0] {
    PMCC_SRC_SLOW,
    PMCC_SRC_MAIN,
    PMCC_SRC_RSVD,
    PMCC_SRC_PLL
  } pmcc_src_t;
  typedef enum {PMCC_M_IDLE, PMCC_M_ARM, PMCC_M_COUNT} pmcc_meas_t;
endpackage

// File: src/pmcc_clk_div.sv
// pmcc_clk_div.sv: one clock output path, source select plus power of
// two prescaler, producing a clock enable pulse and a ready level.
// assumes: source ticks are one-cycle pulses in the CLK domain.
`timescale 1ns/1ps
module pmcc_clk_div #(
  parameter int CW = 7
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [1:0] SRC_SEL,
  input wire logic [2:0] CLOCK_PRESCALER_SEL,
  input wire logic SLOW_TICK,
  input wire logic MAIN_TICK,
  input wire logic PLL_TICK,
  output logic CLK_TICK,
  output logic READY
);
  import pmcc_pkg::*;
  initial begin
    if (CW < 7) $error("prescaler needs at least 7 bits");
  end
  logic [CW-1:0] cnt, next_cnt;
  logic [1:0] last_src, next_last_src;
  logic [2:0] last_clock_prescaler, next_last_clock_prescaler;
  logic tick, next_tick, rdy, next_rdy;
  logic src_tick;
  logic [CW-1:0] limit;
  //////////////////////////////////////////////////////////////////////
  // source select; reserved code gives no clock
  always_comb begin
    case (pmcc_src_t'(SRC_SEL))
      PMCC_SRC_SLOW: src_tick = SLOW_TICK;
      PMCC_SRC_MAIN: src_tick = MAIN_TICK;
      PMCC_SRC_PLL: src_tick = PLL_TICK;
      default: src_tick = 1'b0;
    endcase
    limit = (CLOCK_PRESCALER_SEL == 3'h7) ? '0 :
      CW'((7'h01 << CLOCK_PRESCALER_SEL) - 7'h01);
  end
  // count source ticks; ready drops while a new setting takes effect
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    next_rdy = rdy;
    next_last_src = SRC_SEL;
    next_last_clock_prescaler = CLOCK_PRESCALER_SEL;
    if (SRC_SEL != last_src || CLOCK_PRESCALER_SEL != last_clock_prescaler) begin
      next_cnt = '0;
      next_rdy = 1'b0;
    end else if (src_tick && CLOCK_PRESCALER_SEL != 3'h7) begin
      if (cnt >= limit) begin
        next_cnt = '0;
        next_tick = 1'b1;
        next_rdy = 1'b1;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= '0;
      tick <= 1'b0;
      rdy <= 1'b0;
      last_src <= 2'h0;
      last_clock_prescaler <= 3'h0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
      rdy <= next_rdy;
      last_src <= next_last_src;
      last_clock_prescaler <= next_last_clock_prescaler;
    end
  end
  assign CLK_TICK = tick;
  assign READY = rdy;
endmodule

// File: src/pmcc_top.sv
// pmcc_top.sv: clock controller register block on AHB-Lite with
// measurement, pll settle timing, master and three programmable clocks.
// assumes: slow and main clocks arrive as one-cycle tick pulses in CLK;
// the pll model is a tick generator derived from the divided input.
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module pmcc_top #(
  parameter int NPCK = 3,
  parameter int CNTW = 16
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SLOW_TICK,
  input wire logic MAIN_TICK,
  input wire logic OSC_STABLE,
  output logic MCK_TICK,
  output logic [NPCK-1:0] PCK_TICK,
  output logic USB_TICK,
  output logic PLL_ON,
  output logic IRQ
);
  import pmcc_pkg::*;
  initial begin
    if (NPCK != 3) $error("status layout holds exactly three outputs");
    if (CNTW < 16) $error("count field needs 16 bits");
  end
  //////////////////////////////////////////////////////////////////////
  // register state
  logic [1:0] osc_ctrl, next_osc_ctrl;
  logic [31:0] pll_config, next_pll_config;
  logic [31:0] master_clock_select, next_master_clock_select;
  logic [31:0] prog_clock_config [NPCK];
  logic [31:0] next_prog_clock_config [NPCK];
  logic [31:0] irq_en, next_irq_en;
  logic [31:0] irq_stat, next_irq_stat;
  logic [31:0] clock_status;
  logic [31:0] last_status, next_last_status;
  // bus pipeline
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_addr, next_wr_addr;
  logic [31:0] rdata, next_rdata;
  logic [11:0] a;
  logic wr_fire;
  // measurement
  pmcc_meas_t m_state, next_m_state;
  logic [4:0] m_slow, next_m_slow;
  logic [CNTW-1:0] m_count, next_m_count;
  logic [CNTW-1:0] main_cycle_count, next_main_cycle_count;
  logic measure_valid, next_measure_valid;
  // pll
  logic [5:0] pll_settle_left, next_pll_settle_left;
  logic pll_lock, next_pll_lock;
  logic [7:0] div_cnt, next_div_cnt;
  logic div_tick, next_div_tick;
  logic [10:0] mul_cnt, next_mul_cnt;
  logic pll_tick;
  logic [1:0] usb_cnt, next_usb_cnt;
  logic usb_tick, next_usb_tick;
  logic mck_ready;
  logic [NPCK-1:0] pck_ready;
  logic osc_on;
  //////////////////////////////////////////////////////////////////////
  // field extraction helpers
  function automatic logic [7:0] f_div(input logic [31:0] r);
    f_div = r[`PMCC_PLL_DIV_LSB +: 8];
  endfunction
  function automatic logic [10:0] f_mul(input logic [31:0] r);
    f_mul = r[`PMCC_PLL_MUL_LSB +: 11];
  endfunction
  function automatic logic [31:0] wmask(input logic [31:0] d);
    wmask = d & `PMCC_STAT_MASK;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY; writes land at the
  // data phase edge, reads are captured at the address phase
  assign a = HADDR[11:0];
  assign wr_fire = wr_pend;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata;
  always_comb begin
    next_wr_pend = HSEL && HREADY && HTRANS[1] && HWRITE;
    next_wr_addr = a;
    next_rdata = rdata;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (a)
        `PMCC_OFS_OSC_CTRL: next_rdata = {30'h0, osc_ctrl};
        `PMCC_OFS_MEASURE:
          next_rdata = {15'h0, measure_valid, main_cycle_count[15:0]};
        `PMCC_OFS_PLL: next_rdata = pll_config;
        `PMCC_OFS_MCK: next_rdata = master_clock_select;
        `PMCC_OFS_PCK0: next_rdata = prog_clock_config[0];
        `PMCC_OFS_PCK1: next_rdata = prog_clock_config[1];
        `PMCC_OFS_PCK2: next_rdata = prog_clock_config[2];
        `PMCC_OFS_SR: next_rdata = clock_status;
        `PMCC_OFS_IMR: next_rdata = wmask(~irq_en);
        `PMCC_OFS_IRQ_STAT: next_rdata = irq_stat;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      rdata <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rdata <= next_rdata;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // configuration registers and interrupt enable/status
  always_comb begin
    next_osc_ctrl = osc_ctrl;
    next_pll_config = pll_config;
    next_master_clock_select = master_clock_select;
    for (int i = 0; i < NPCK; i++) begin
      next_prog_clock_config[i] = prog_clock_config[i];
    end
    next_irq_en = irq_en;
    next_last_status = clock_status;
    // rising edges of status set sticky bits; set beats clear
    next_irq_stat = irq_stat;
    if (wr_fire && wr_addr == `PMCC_OFS_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~wmask(HWDATA);
    end
    next_irq_stat = next_irq_stat | (clock_status & ~last_status);
    if (wr_fire) begin
      case (wr_addr)
        `PMCC_OFS_OSC_CTRL: next_osc_ctrl = HWDATA[1:0];
        `PMCC_OFS_PLL: next_pll_config = HWDATA & `PMCC_PLL_MASK;
        `PMCC_OFS_MCK: next_master_clock_select = HWDATA & `PMCC_CLK_MASK;
        `PMCC_OFS_PCK0: next_prog_clock_config[0] = HWDATA & `PMCC_CLK_MASK;
        `PMCC_OFS_PCK1: next_prog_clock_config[1] = HWDATA & `PMCC_CLK_MASK;
        `PMCC_OFS_PCK2: next_prog_clock_config[2] = HWDATA & `PMCC_CLK_MASK;
        `PMCC_OFS_IER: next_irq_en = irq_en | wmask(HWDATA);
        `PMCC_OFS_IDR: next_irq_en = irq_en & ~wmask(HWDATA);
        default: next_irq_en = irq_en;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      osc_ctrl <= 2'h0;
      pll_config <= `PMCC_PLL_RESET;
      master_clock_select <= `PMCC_MCK_RESET;
      for (int i = 0; i < NPCK; i++) begin
        prog_clock_config[i] <= 32'h00000000;
      end
      irq_en <= 32'h00000000;
      irq_stat <= 32'h00000000;
      last_status <= 32'h00000000;
    end else begin
      osc_ctrl <= next_osc_ctrl;
      pll_config <= next_pll_config;
      master_clock_select <= next_master_clock_select;
      prog_clock_config <= next_prog_clock_config;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      last_status <= next_last_status;
    end
  end
  // level interrupt: enabled sticky event bits
  assign IRQ = |(irq_stat & irq_en);
  //////////////////////////////////////////////////////////////////////
  // status assembly; bypass counts as stable without waiting
  assign osc_on = osc_ctrl[0] | osc_ctrl[1];
  always_comb begin
    clock_status = 32'h00000000;
    clock_status[`PMCC_BIT_OSC] = osc_ctrl[1] | (osc_ctrl[0] & OSC_STABLE);
    clock_status[`PMCC_BIT_LOCK] = pll_lock;
    clock_status[`PMCC_BIT_MRDY] = mck_ready;
    clock_status[`PMCC_BIT_PRDY0 +: 3] = pck_ready;
  end
  //////////////////////////////////////////////////////////////////////
  // frequency measurement: align to a slow tick, then count main ticks
  // over sixteen slow periods and keep re-measuring while on
  always_comb begin
    next_m_state = m_state;
    next_m_slow = m_slow;
    next_m_count = m_count;
    next_main_cycle_count = main_cycle_count;
    next_measure_valid = measure_valid;
    case (m_state)
      PMCC_M_IDLE: begin
        if (osc_on) next_m_state = PMCC_M_ARM;
      end
      PMCC_M_ARM: begin
        if (SLOW_TICK) begin
          next_m_state = PMCC_M_COUNT;
          next_m_slow = 5'h00;
          next_m_count = '0;
        end
      end
      PMCC_M_COUNT: begin
        if (MAIN_TICK) next_m_count = m_count + CNTW'(1);
        if (SLOW_TICK) begin
          next_m_slow = m_slow + 5'h01;
          if (m_slow + 5'h01 == `PMCC_MEAS_WINDOW) begin
            next_main_cycle_count = next_m_count;
            next_measure_valid = 1'b1;
            next_m_state = PMCC_M_ARM;
          end
        end
      end
      default: next_m_state = PMCC_M_IDLE;
    endcase
    if (!osc_on) begin
      next_m_state = PMCC_M_IDLE;
      next_measure_valid = 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      m_state <= PMCC_M_IDLE;
      m_slow <= 5'h00;
      m_count <= '0;
      main_cycle_count <= '0;
      measure_valid <= 1'b0;
    end else begin
      m_state <= next_m_state;
      m_slow <= next_m_slow;
      m_count <= next_m_count;
      main_cycle_count <= next_main_cycle_count;
      measure_valid <= next_measure_valid;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // pll: divider, settle counter, multiplier tick model, usb divider;
  // the multiplied clock is modelled as a tick every divided input
  // tick because a synchronous design cannot run faster than CLK
  assign PLL_ON = f_mul(pll_config) != 11'h000;
  assign pll_tick = PLL_ON && pll_lock && div_tick;
  always_comb begin
    next_div_cnt = div_cnt;
    next_div_tick = 1'b0;
    next_pll_settle_left = pll_settle_left;
    next_pll_lock = pll_lock;
    next_mul_cnt = f_mul(pll_config);
    next_usb_cnt = usb_cnt;
    next_usb_tick = 1'b0;
    // input divider from the main clock
    if (MAIN_TICK) begin
      case (f_div(pll_config))
        8'h00: next_div_tick = 1'b0;
        8'h01: next_div_tick = 1'b1;
        default: begin
          if (div_cnt + 8'h01 >= f_div(pll_config)) begin
            next_div_cnt = 8'h00;
            next_div_tick = 1'b1;
          end else begin
            next_div_cnt = div_cnt + 8'h01;
          end
        end
      endcase
    end
    // any pll register write restarts the settle count in slow clocks
    if (wr_fire && wr_addr == `PMCC_OFS_PLL) begin
      next_pll_settle_left = HWDATA[`PMCC_PLL_CNT_LSB +: 6];
      next_pll_lock = 1'b0;
      next_div_cnt = 8'h00;
    end else if (!pll_lock && SLOW_TICK) begin
      if (pll_settle_left == 6'h00) next_pll_lock = 1'b1;
      else next_pll_settle_left = pll_settle_left - 6'h01;
    end
    // usb divider: 1, 2, 4; reserved code stops the clock
    if (pll_tick) begin
      next_usb_cnt = usb_cnt + 2'h1;
      case (pll_config[`PMCC_PLL_USB_LSB +: 2])
        2'h0: next_usb_tick = 1'b1;
        2'h1: next_usb_tick = usb_cnt[0];
        2'h2: next_usb_tick = (usb_cnt == 2'h3);
        default: next_usb_tick = 1'b0;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= 8'h00;
      div_tick <= 1'b0;
      pll_settle_left <= 6'h00;
      pll_lock <= 1'b0;
      mul_cnt <= 11'h000;
      usb_cnt <= 2'h0;
      usb_tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      div_tick <= next_div_tick;
      pll_settle_left <= next_pll_settle_left;
      pll_lock <= next_pll_lock;
      mul_cnt <= next_mul_cnt;
      usb_cnt <= next_usb_cnt;
      usb_tick <= next_usb_tick;
    end
  end
  assign USB_TICK = usb_tick;
  //////////////////////////////////////////////////////////////////////
  // master clock and programmable outputs share one divider module
  pmcc_clk_div #(.CW(7)) u_mck (
    .CLK(CLK),
    .RST_N(RST_N),
    .SRC_SEL(master_clock_select[1:0]),
    .CLOCK_PRESCALER_SEL(master_clock_select[4:2]),
    .SLOW_TICK(SLOW_TICK),
    .MAIN_TICK(MAIN_TICK),
    .PLL_TICK(pll_tick),
    .CLK_TICK(MCK_TICK),
    .READY(mck_ready)
  );
  for (genvar g = 0; g < NPCK; g++) begin : g_pck
    pmcc_clk_div #(.CW(7)) u_pck (
      .CLK(CLK),
      .RST_N(RST_N),
      .SRC_SEL(prog_clock_config[g][1:0]),
      .CLOCK_PRESCALER_SEL(prog_clock_config[g][4:2]),
      .SLOW_TICK(SLOW_TICK),
      .MAIN_TICK(MAIN_TICK),
      .PLL_TICK(pll_tick),
      .CLK_TICK(PCK_TICK[g]),
      .READY(pck_ready[g])
    );
  end
endmodule

// File: dv/pmcc_top_sva.sv
// pmcc_top_sva.sv: port-level assertions for the clock controller.
// assumes: bound into pmcc_top, one CLK domain, async active-low RST_N.
`timescale 1ns/1ps
module pmcc_top_sva #(
  parameter int NPCK = 3,
  parameter int CNTW = 16
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SLOW_TICK,
  input wire logic MAIN_TICK,
  input wire logic OSC_STABLE,
  input wire logic MCK_TICK,
  input wire logic [NPCK-1:0] PCK_TICK,
  input wire logic USB_TICK,
  input wire logic PLL_ON,
  input wire logic IRQ
);
  logic ap;
  logic dp_wr, next_dp_wr;
  logic [11:0] dp_a, next_dp_a;
  logic [10:0] en_sh, next_en_sh;
  ////////////////////////////////////////////////////////////////////////
  // write data phase tracking plus a shadow of the interrupt enables
  always_comb begin
    ap = HSEL && HREADY && HTRANS[1];
    next_dp_wr = ap && HWRITE;
    next_dp_a = ap ? HADDR[11:0] : dp_a;
    next_en_sh = en_sh;
    if (dp_wr && dp_a == 12'h060) begin
      next_en_sh = en_sh | (HWDATA[10:0] & 11'h70D);
    end
    if (dp_wr && dp_a == 12'h064) begin
      next_en_sh = en_sh & ~HWDATA[10:0];
    end
  end
  // registered on the edge that ends the data phase, as the design does
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_wr <= 1'b0;
      dp_a <= 12'h000;
      en_sh <= 11'h000;
    end else begin
      dp_wr <= next_dp_wr;
      dp_a <= next_dp_a;
      en_sh <= next_en_sh;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_okay_resp: assert property (HRESP == 1'b0)
    else $error("slave response not OKAY");
  a_ready_high: assert property (HREADYOUT == 1'b1)
    else $error("wait state inserted");
  a_rdata_hold: assert property (!(ap && !HWRITE) |=> $stable(HRDATA))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property
    (ap && !HWRITE && HADDR == 32'h0F0 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_pll_on_set: assert property
    (dp_wr && dp_a == 12'h02C && HWDATA[26:16] != 11'h0 |=> PLL_ON)
    else $error("pll off with nonzero multiplier");
  a_pll_off: assert property
    (dp_wr && dp_a == 12'h02C && HWDATA[26:16] == 11'h0 |=> !PLL_ON)
    else $error("pll on with zero multiplier");
  a_usb_idle: assert property (!PLL_ON [*4] |-> !USB_TICK)
    else $error("usb tick with pll off");
  a_irq_masked: assert property ((en_sh == 11'h0) [*2] |-> !IRQ)
    else $error("interrupt with all sources disabled");
  a_idr_drops: assert property
    (dp_wr && dp_a == 12'h064 && HWDATA[10:0] == 11'h70D |-> ##[1:2] !IRQ)
    else $error("interrupt held after disable");
  a_clr_drops: assert property
    (dp_wr && dp_a == 12'h070 && HWDATA[10:0] == 11'h70D |-> ##[1:2] !IRQ)
    else $error("interrupt held after clear");
  c_irq: cover property (IRQ);
  c_pll_on: cover property ($rose(PLL_ON));
  c_mck: cover property (MCK_TICK);
  c_usb: cover property (USB_TICK);
endmodule
bind pmcc_top pmcc_top_sva #(.NPCK(NPCK), .CNTW(CNTW)) u_sva (.*);

// File: dv/pmcc_top_bench.sv
// pmcc_top_bench.sv: self-checking bench for the clock controller.
// assumes: design, package and checker compiled before this file.
`timescale 1ns/1ps
module pmcc_top_bench;
  import pmcc_pkg::*;
  localparam int SP = 40;
  localparam int LIMIT = 40000;
  logic CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  logic OSC_STABLE, MCK_TICK, USB_TICK, PLL_ON, IRQ;
  logic SLOW_TICK = 1'b0;
  logic MAIN_TICK = 1'b0;
  logic [31:0] HADDR, HWDATA, HRDATA, q;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, PCK_TICK;
  int error_cnt = 0;
  int n_compared = 0;
  int sc = 0;
  int cyc = 0;
  int n_slow = 0;
  assign HREADY = HREADYOUT;
  pmcc_top dut (.*);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // slow tick every SP cycles, main tick every 2; the cycle cap cuts hangs
  always @(posedge CLK) begin
    sc <= (sc == SP - 1) ? 0 : sc + 1;
    SLOW_TICK <= (sc == SP - 1);
    MAIN_TICK <= ~MAIN_TICK;
    if (SLOW_TICK) n_slow <= n_slow + 1;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single transfer; waits for a rising edge first so that every
  // change lands just after it, whatever edge the caller left on
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'b10;
    HWRITE <= w;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'b1);
    q = HRDATA;
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, {20'h0, a}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, {20'h0, a}, d);
  endtask
  // flags may lag a few cycles, so reread until they settle
  task automatic poll(input logic [11:0] a, input logic [31:0] m, v,
      input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd(a);
      if ((q & m) === v) break;
    end
    chk(q & m, v, "flag");
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(negedge CLK);
    chk({31'h0, IRQ}, {31'h0, v}, "irq level");
  endtask
  function automatic logic tk(input int s);
    return s == 0 ? MCK_TICK : s == 4 ? USB_TICK : PCK_TICK[s - 1];
  endfunction
  task automatic nxt(input int s, inout int c);
    do begin
      @(negedge CLK);
      c++;
    end while (tk(s) !== 1'b1 && c < 3000);
  endtask
  // first interval after a change may be short, so skip it; 0 if silent
  task automatic per(input int s, output int n);
    int c;
    int k;
    c = 0;
    nxt(s, c);
    nxt(s, c);
    k = c;
    nxt(s, c);
    n = (c >= 3000) ? 0 : c - k;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(12'h02C);
    chk(q, 32'h0000_3F00, "pll reset");
    rd(12'h030);
    chk(q, 32'h0000_0001, "master reset");
    rd(12'h040);
    chk(q, 32'h0, "prog reset");
    rd(12'h0F0);
    chk(q, 32'h0, "unmapped");
  endtask
  task automatic t_irq();
    int s0;
    int i;
    wr(12'h02C, 32'h0001_0301);
    s0 = n_slow;
    rd(12'h068);
    chk(q & 32'h4, 32'h0, "lock early");
    wr(12'h070, 32'h70D);
    wr(12'h060, 32'h4);
    for (i = 0; i < 600 && IRQ !== 1'b1; i++) @(negedge CLK);
    chk(n_slow - s0, 4, "settle ticks");
    rd(12'h068);
    chk(q & 32'h4, 32'h4, "locked");
    rd(12'h06C);
    chk(q & 32'h70D, 32'h709, "mask one");
    wr(12'h060, 32'h1);
    irq_is(1'b1);
    rd(12'h06C);
    chk(q & 32'h70D, 32'h708, "mask two");
    wr(12'h064, 32'h4);
    irq_is(1'b0);
    wr(12'h060, 32'h4);
    irq_is(1'b1);
    wr(12'h070, 32'h4);
    irq_is(1'b0);
    wr(12'h064, 32'h70D);
    rd(12'h06C);
    chk(q & 32'h70D, 32'h70D, "mask none");
  endtask
  task automatic t_meas();
    rd(12'h024);
    chk(q & 32'h1_0000, 32'h0, "valid off");
    // enable the oscillator first: the flag needs it on and stable
    OSC_STABLE <= 1'b0;
    wr(12'h020, 32'h1);
    poll(12'h068, 32'h1, 32'h0, 20);
    OSC_STABLE <= 1'b1;
    poll(12'h068, 32'h1, 32'h1, 20);
    poll(12'h024, 32'h1_0000, 32'h1_0000, 800);
    chk(q & 32'hFFFF, 16 * SP / 2, "main count");
    wr(12'h020, 32'h0);
    poll(12'h024, 32'h1_0000, 32'h0, 5);
  endtask
  task automatic t_clk();
    int n;
    int p;
    for (p = 0; p < 7; p++) begin
      wr(12'h030, (p << 2) | 1);
      per(0, n);
      chk(n, 2 << p, "master div");
    end
    wr(12'h030, 32'h0);
    per(0, n);
    chk(n, SP, "master slow");
    poll(12'h068, 32'h8, 32'h8, 20);
    for (p = 0; p < 3; p++) begin
      wr(12'h040 + 4 * p, p << 2);
      per(p + 1, n);
      chk(n, SP << p, "prog div");
      poll(12'h068, 32'h100 << p, 32'h100 << p, 20);
    end
    wr(12'h048, 32'h19);
    per(3, n);
    chk(n, 128, "prog main");
    wr(12'h040, 32'h2);
    per(1, n);
    chk(n, 0, "prog src rsvd");
    poll(12'h068, 32'h100, 32'h0, 5);
    wr(12'h040, 32'h1D);
    per(1, n);
    chk(n, 0, "prog clock_prescaler rsvd");
  endtask
  task automatic t_pll();
    int n;
    int b;
    int u;
    for (u = 0; u < 3; u++) begin
      wr(12'h02C, 32'h0001_8301 | (u << 28));
      per(4, n);
      if (u == 0) b = n;
      chk(n, b << u, "usb div");
    end
    chk(b > 0, 1, "pll runs");
    rd(12'h02C);
    chk(q, 32'h2001_8301, "pll readback");
    wr(12'h044, 32'h3);
    per(2, n);
    chk(n, b, "prog pll");
    wr(12'h02C, 32'h0001_0302);
    per(4, n);
    chk(n, 2 * b, "div two");
    wr(12'h02C, 32'h3001_0301);
    per(4, n);
    chk(n, 0, "usb rsvd");
    wr(12'h02C, 32'h0001_0300);
    per(4, n);
    chk(n, 0, "div zero");
    wr(12'h02C, 32'h0000_0301);
    @(negedge CLK);
    chk({31'h0, PLL_ON}, 32'h0, "pll off");
    per(4, n);
    chk(n, 0, "usb off");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    RST_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    OSC_STABLE = 1'b1;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_irq();
    t_meas();
    t_clk();
    t_pll();
    stop_test();
  end
endmodule
